// ===== memsize_params.svh
// offsets, reset values, setting codes and memory map bounds of the memory size block
`ifndef MEMSIZE_PARAMS_SVH
`define MEMSIZE_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_ROM_SEL 8'h00
`define OFS_XRAM_SEL 8'h04
`define OFS_ANALOG 8'h08
`define OFS_BOOT_SWAP 8'h0c
`define OFS_PROBE_ADDR 8'h10
`define OFS_PROBE_REGION 8'h14
`define OFS_STATUS 8'h18
`define OFS_CAPACITY 8'h1c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ROM_SEL_RESET 8'hcf
`define XRAM_SEL_RESET 8'h0c
`define ANALOG_RESET 8'hff

// ----------------------------------------------------------------
// setting codes and capacities in KB
// ----------------------------------------------------------------
`define ROM_SEL_32K 8'hc8
`define ROM_SEL_48K 8'hcc
`define ROM_SEL_60K 8'hcf
`define XRAM_SEL_NONE 8'h0c
`define XRAM_SEL_1K 8'h0a
`define XRAM_SEL_2K 8'h0b
`define XRAM_SEL_4K 8'h04
`define XRAM_SEL_6K 8'h00
`define KB_32 8'h20
`define KB_48 8'h30
`define KB_60 8'h3c
`define KB_0 8'h00
`define KB_1 8'h01
`define KB_2 8'h02
`define KB_4 8'h04
`define KB_6 8'h06

// ----------------------------------------------------------------
// address map of the 64 KB space (17 bits so limits fit)
// ----------------------------------------------------------------
`define VECTOR_END 17'h0003f
`define CALLT_END 17'h0007f
`define OPTION_BASE 17'h00080
`define OPTION_END 17'h00084
`define SECID_BASE 17'h00085
`define SECID_END 17'h0008e
`define SWAP_OFFSET 17'h01000
`define XRAM_END 17'h0f800
`define HSRAM_BASE 17'h0fb00
`define HSRAM_END 17'h0feff
`define SFR_BASE 17'h0ff00

`endif

// ===== memsize_pkg.sv
// types shared by the memory size block
package memsize_pkg;

    typedef enum logic [3:0] {
        REGION_NONE,
        REGION_VECTOR,
        REGION_CALLT,
        REGION_OPTION,
        REGION_SECID,
        REGION_ROM,
        REGION_XRAM,
        REGION_HSRAM,
        REGION_SFR
    } region_t;

    typedef struct packed {
        region_t region;
        logic [7:0] rom_kb;
        logic [7:0] xram_kb;
        logic rom_ok;
        logic xram_ok;
        logic overlap;
    } decode_t;

endpackage : memsize_pkg

// ===== region_decoder.sv
// address region decoder driven by the two size selections
`include "memsize_params.svh"

module region_decoder #(
    parameter int ADDR_W = 16
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] rom_size_select,
    input wire logic [7:0] xram_size_select,
    input wire logic boot_swap,
    output memsize_pkg::decode_t info
);
    import memsize_pkg::*;

    generate
        if (ADDR_W != 16) begin : g_bad_width
            $error("region_decoder serves a 16-bit address space only");
        end
    endgenerate

    always_comb begin
        logic [16:0] a;
        logic [16:0] rom_limit;
        logic [16:0] xram_base;
        logic in_opt;
        logic in_sec;
        a = {1'b0, addr};
        rom_limit = '0;
        xram_base = '0;
        in_opt = 1'b0;
        in_sec = 1'b0;
        info = '0;
        info.region = REGION_NONE;
        info.rom_ok = 1'b1;
        info.xram_ok = 1'b1;
        case (rom_size_select)
            `ROM_SEL_32K: info.rom_kb = `KB_32;
            `ROM_SEL_48K: info.rom_kb = `KB_48;
            `ROM_SEL_60K: info.rom_kb = `KB_60;
            default: info.rom_ok = 1'b0;
        endcase
        case (xram_size_select)
            `XRAM_SEL_NONE: info.xram_kb = `KB_0;
            `XRAM_SEL_1K: info.xram_kb = `KB_1;
            `XRAM_SEL_2K: info.xram_kb = `KB_2;
            `XRAM_SEL_4K: info.xram_kb = `KB_4;
            `XRAM_SEL_6K: info.xram_kb = `KB_6;
            default: info.xram_ok = 1'b0;
        endcase
        rom_limit = {info.rom_kb[6:0], 10'h000};
        xram_base = `XRAM_END - {info.xram_kb[6:0], 10'h000};
        info.overlap = (info.xram_kb != `KB_0) && (rom_limit > xram_base);
        // boot swap duplicates option bytes and security id one block up
        in_opt = (a >= `OPTION_BASE && a <= `OPTION_END) || (boot_swap &&
            a >= `OPTION_BASE + `SWAP_OFFSET && a <= `OPTION_END + `SWAP_OFFSET);
        in_sec = (a >= `SECID_BASE && a <= `SECID_END) || (boot_swap &&
            a >= `SECID_BASE + `SWAP_OFFSET && a <= `SECID_END + `SWAP_OFFSET);
        if (a < rom_limit) begin
            if (a <= `VECTOR_END) begin
                info.region = REGION_VECTOR;
            end else if (a <= `CALLT_END) begin
                info.region = REGION_CALLT;
            end else if (in_opt) begin
                info.region = REGION_OPTION;
            end else if (in_sec) begin
                info.region = REGION_SECID;
            end else begin
                info.region = REGION_ROM;
            end
        end else if (info.xram_kb != `KB_0 && a >= xram_base && a < `XRAM_END) begin
            info.region = REGION_XRAM;
        end else if (a >= `HSRAM_BASE && a <= `HSRAM_END) begin
            info.region = REGION_HSRAM;
        end else if (a >= `SFR_BASE) begin
            info.region = REGION_SFR;
        end
    end

endmodule : region_decoder

// ===== memsize_ctrl.sv
// memory size configuration block with AHB-Lite register slave
//
// Function
// - the decoder covers a flat 64 KB space holding ROM, high-speed RAM and expansion RAM.
// - after reset the ROM selection reads cfh and the expansion RAM selection reads 0ch.
// - ROM selection c8h, cch, cfh decode 32, 48, 60 KB, with 1 KB high-speed RAM always.
// - expansion RAM selection 0ch, 0ah, 0bh, 04h, 00h decode 0, 1, 2, 4, 6 KB.
// - the eight port 2 converter pins come out of reset in analog input mode.
// - 0000h-003fh is the vector table, low byte at even address, high at odd.
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`include "memsize_params.svh"

module memsize_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] cpu_addr,
    output memsize_pkg::region_t cpu_region,
    output logic [7:0] port2_analog_mode,
    output logic [7:0] rom_size_select,
    output logic [7:0] xram_size_select
);
    import memsize_pkg::*;

    typedef struct packed {
        logic [7:0] rom_sel;
        logic [7:0] xram_sel;
        logic [7:0] analog;
        logic boot_swap;
        logic [15:0] probe;
        logic rom_written;
        logic xram_written;
        logic analog_written;
        logic order_err;
        logic ph_valid;
        logic ph_write;
        logic ph_low;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        region_t region;
    } state_t;

    state_t s;
    state_t next_s;
    decode_t cpu_info;
    decode_t probe_info;
    logic take;

    // ----------------------------------------------------------------
    // decoders: one for the processor path, one for software probing
    // ----------------------------------------------------------------
    region_decoder #(.ADDR_W(16)) u_cpu_dec (
        .addr(cpu_addr),
        .rom_size_select(s.rom_sel),
        .xram_size_select(s.xram_sel),
        .boot_swap(s.boot_swap),
        .info(cpu_info)
    );

    region_decoder #(.ADDR_W(16)) u_probe_dec (
        .addr(s.probe),
        .rom_size_select(s.rom_sel),
        .xram_size_select(s.xram_sel),
        .boot_swap(s.boot_swap),
        .info(probe_info)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    assign take = hsel && hready && htrans[1];

    always_comb begin
        next_s = s;
        next_s.ph_valid = take;
        next_s.ph_write = hwrite;
        next_s.ph_low = (haddr[31:8] == 24'h000000);
        next_s.ph_addr = haddr[7:0];
        next_s.region = cpu_info.region;
        // data phase write; byte lane 0 carries the setting
        if (s.ph_valid && s.ph_write && s.ph_low) begin
            case (s.ph_addr)
                `OFS_ROM_SEL: begin
                    next_s.rom_sel = hwdata[7:0];
                    next_s.rom_written = 1'b1;
                    next_s.order_err = 1'b0;
                end
                `OFS_XRAM_SEL: begin
                    next_s.xram_sel = hwdata[7:0];
                    next_s.xram_written = 1'b1;
                    // flags expansion RAM set before any ROM setting
                    if (!s.rom_written) begin
                        next_s.order_err = 1'b1;
                    end
                end
                `OFS_ANALOG: begin
                    next_s.analog = hwdata[7:0];
                    next_s.analog_written = 1'b1;
                end
                `OFS_BOOT_SWAP: next_s.boot_swap = hwdata[0];
                `OFS_PROBE_ADDR: next_s.probe = hwdata[15:0];
                default: ;
            endcase
        end
        // read data registered at the address phase, valid in the data phase
        if (take && !hwrite) begin
            next_s.rdata = 32'h00000000;
            if (haddr[31:8] == 24'h000000) begin
                case (haddr[7:0])
                    `OFS_ROM_SEL: next_s.rdata = {24'h000000, s.rom_sel};
                    `OFS_XRAM_SEL: next_s.rdata = {24'h000000, s.xram_sel};
                    `OFS_ANALOG: next_s.rdata = {24'h000000, s.analog};
                    `OFS_BOOT_SWAP: next_s.rdata = {31'h00000000, s.boot_swap};
                    `OFS_PROBE_ADDR: next_s.rdata = {16'h0000, s.probe};
                    `OFS_PROBE_REGION: next_s.rdata = {28'h0000000, probe_info.region};
                    `OFS_STATUS: next_s.rdata = {28'h0000000, s.order_err,
                        probe_info.overlap, probe_info.xram_ok, probe_info.rom_ok};
                    `OFS_CAPACITY: next_s.rdata = {16'h0000, probe_info.xram_kb,
                        probe_info.rom_kb};
                    default: next_s.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.rom_sel <= `ROM_SEL_RESET;
            s.xram_sel <= `XRAM_SEL_RESET;
            s.analog <= `ANALOG_RESET;
            s.region <= REGION_NONE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpu_region = s.region;
    assign port2_analog_mode = s.analog;
    assign rom_size_select = s.rom_sel;
    assign xram_size_select = s.xram_sel;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_rom_write;
        s.ph_valid && s.ph_write && s.ph_low && s.ph_addr == `OFS_ROM_SEL;
    endsequence

    sequence s_xram_write;
        s.ph_valid && s.ph_write && s.ph_low && s.ph_addr == `OFS_XRAM_SEL;
    endsequence

    a_rom_reset_value: assert property (!s.rom_written |-> rom_size_select == 8'hcf)
        else $error("rom size selection left its reset value unwritten");
    a_xram_reset_value: assert property (!s.xram_written |-> xram_size_select == 8'h0c)
        else $error("expansion ram selection left its reset value unwritten");
    a_analog_reset_mode: assert property (!s.analog_written |-> port2_analog_mode == 8'hff)
        else $error("port 2 pins not in analog mode after reset");
    a_new_setting_used: assert property (s_rom_write |=> rom_size_select == $past(hwdata[7:0]))
        else $error("rom size write not applied");
    a_xram_setting_used: assert property (s_xram_write
        |=> xram_size_select == $past(hwdata[7:0]))
        else $error("expansion ram size write not applied");
    a_rom_code_decode: assert property (rom_size_select == 8'hcc |-> probe_info.rom_kb == 8'h30
        && probe_info.rom_ok)
        else $error("48 KB rom code decoded wrongly");
    a_xram_code_decode: assert property (xram_size_select == 8'h00 |-> probe_info.xram_kb == 8'h06
        && probe_info.xram_ok)
        else $error("6 KB expansion ram code decoded wrongly");
    // region register still holds its reset value at the release edge
    a_vector_area: assert property (hresetn && cpu_addr <= 16'h003f && cpu_info.rom_ok
        |=> cpu_region == REGION_VECTOR)
        else $error("vector table address not decoded as vector area");
    a_top_page_sfr: assert property (hresetn && cpu_addr >= 16'hff00
        |=> cpu_region == REGION_SFR)
        else $error("top page of the 64 KB space not decoded");
    a_read_in_data: assert property (take && !hwrite && haddr == 32'h00000000
        |=> hrdata == {24'h000000, $past(rom_size_select)})
        else $error("rom selection read back wrong");

endmodule : memsize_ctrl

// ===== internal_memory_size_config_tb.sv
// self-checking bench for the memory size configuration block
`include "memsize_params.svh"

module internal_memory_size_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import memsize_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] cpu_addr = 16'h0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    region_t cpu_region;
    logic [7:0] port2_analog_mode;
    logic [7:0] rom_size_select;
    logic [7:0] xram_size_select;
    logic [31:0] bus_q[$];
    logic [31:0] rg_q[$];
    logic rd_dp = 1'b0;
    logic rg_v = 1'b0;
    logic rg_d = 1'b0;
    int err_total = 0;
    int cmp_count = 0;
    int seed = 32'h6e37;
    logic [7:0] rc[3] = '{8'hc8, 8'hcc, 8'hcf};
    int kb_r[3] = '{32, 48, 60};
    logic [7:0] xc[5] = '{8'h0c, 8'h0a, 8'h0b, 8'h04, 8'h00};
    int kb_x[5] = '{0, 1, 2, 4, 6};
    logic [15:0] fx[14] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h0084,
        16'h0085, 16'h008e, 16'h008f, 16'h1080, 16'h1084, 16'h1085, 16'h108e, 16'h108f};

    assign hready = hreadyout;
    always #50 hclk = ~hclk;

    memsize_ctrl memsize_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
        .cpu_region(cpu_region), .port2_analog_mode(port2_analog_mode),
        .rom_size_select(rom_size_select), .xram_size_select(xram_size_select));

    // ----------------------------------------------------------------
    // compare, verdict, bus and decode tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 16) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 16) begin
            err_total++;
            conclude();
        end
    endtask : wait_rdy

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask : wr

    task rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        rd_dp <= 1'b1;
        bus_q.push_back(exp);
        wait_rdy();
        rd_dp <= 1'b0;
    endtask : rd

    task probe(input logic [15:0] a, input region_t exp);
        @(posedge hclk);
        cpu_addr <= a;
        rg_v <= 1'b1;
        rg_q.push_back({28'h0, exp});
        @(posedge hclk);
        rg_v <= 1'b0;
    endtask : probe

    // fixed areas at the bottom of ROM, swap copy one 4 KB block up
    function automatic region_t fixed_area(input logic [15:0] a, input logic sw);
        if (a[12] && !sw) begin
            return REGION_ROM;
        end
        if (a[7:0] <= 8'h3f) begin
            return REGION_VECTOR;
        end
        if (a[7:0] <= 8'h7f) begin
            return REGION_CALLT;
        end
        if (a[7:0] <= 8'h84) begin
            return REGION_OPTION;
        end
        if (a[7:0] <= 8'h8e) begin
            return REGION_SECID;
        end
        return REGION_ROM;
    endfunction : fixed_area

    // ----------------------------------------------------------------
    // monitor: oldest note against each result
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        rg_d <= rg_v;
        if (rd_dp) begin
            check(hrdata, bus_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
        if (rg_d) begin
            check({28'h0, cpu_region}, rg_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        int i;
        int k;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check({24'h0, rom_size_select}, 32'hcf);
        check({24'h0, xram_size_select}, 32'h0c);
        check({24'h0, port2_analog_mode}, 32'hff);
        rd(`OFS_ROM_SEL, 32'hcf);
        rd(`OFS_XRAM_SEL, 32'h0c);
        rd(`OFS_ANALOG, 32'hff);
        rd(`OFS_CAPACITY, 32'h3c);
        wr(`OFS_CAPACITY, 32'hffffffff);
        rd(`OFS_CAPACITY, 32'h3c);
        wr(32'h20, 32'hffffffff);
        rd(32'h20, 32'h0);
        rd(32'h100, 32'h0);
        // expansion size first, then the right order
        wr(`OFS_XRAM_SEL, 32'h0a);
        rd(`OFS_STATUS, 32'hb);
        wr(`OFS_ROM_SEL, 32'hc8);
        rd(`OFS_STATUS, 32'h3);
        for (i = 0; i < 3; i++) begin
            r = $random(seed);
            wr(`OFS_ROM_SEL, {r[31:8], rc[i]});
            wr(`OFS_XRAM_SEL, 32'h0c);
            check({24'h0, rom_size_select}, {24'h0, rc[i]});
            rd(`OFS_ROM_SEL, {24'h0, rc[i]});
            rd(`OFS_CAPACITY, 32'(kb_r[i]));
            probe(16'(kb_r[i] * 1024 - 1), REGION_ROM);
            probe(16'(kb_r[i] * 1024), REGION_NONE);
            probe(16'hfb00, REGION_HSRAM);
            probe(16'hfeff, REGION_HSRAM);
            probe(16'hff00, REGION_SFR);
        end
        wr(`OFS_ROM_SEL, 32'hc8);
        for (k = 0; k < 5; k++) begin
            wr(`OFS_XRAM_SEL, {24'h0, xc[k]});
            rd(`OFS_CAPACITY, 32'(kb_x[k] * 256 + 32));
            probe(16'(32'hf800 - kb_x[k] * 1024 - 1), REGION_NONE);
            if (kb_x[k] > 0) begin
                probe(16'(32'hf800 - kb_x[k] * 1024), REGION_XRAM);
                probe(16'hf7ff, REGION_XRAM);
            end
            probe(16'hf800, REGION_NONE);
        end
        wr(`OFS_XRAM_SEL, 32'h0c);
        for (k = 0; k < 2; k++) begin
            wr(`OFS_BOOT_SWAP, 32'(k));
            for (i = 0; i < 14; i++) begin
                probe(fx[i], fixed_area(fx[i], k[0]));
            end
        end
        wr(`OFS_PROBE_ADDR, 32'h0040);
        rd(`OFS_PROBE_REGION, {28'h0, REGION_CALLT});
        // overlapping sizes still decode ROM first
        wr(`OFS_ROM_SEL, 32'hcf);
        wr(`OFS_XRAM_SEL, 32'h00);
        rd(`OFS_STATUS, 32'h7);
        rd(`OFS_CAPACITY, 32'h063c);
        probe(16'he000, REGION_ROM);
        // banked part and emulated product: 48 KB rom setting, then 4 KB expansion
        wr(`OFS_ROM_SEL, {24'h0, `ROM_SEL_48K});
        wr(`OFS_XRAM_SEL, {24'h0, `XRAM_SEL_4K});
        rd(`OFS_CAPACITY, 32'h0430);
        rd(`OFS_STATUS, 32'h3);
        probe(16'hbfff, REGION_ROM);
        probe(16'he800, REGION_XRAM);
        repeat (3) begin
            r = $random(seed);
            wr(`OFS_ANALOG, r);
            #1;
            check({24'h0, port2_analog_mode}, {24'h0, r[7:0]});
            rd(`OFS_ANALOG, {24'h0, r[7:0]});
        end
        // second reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check({24'h0, rom_size_select}, 32'hcf);
        check({24'h0, xram_size_select}, 32'h0c);
        check({24'h0, port2_analog_mode}, 32'hff);
        repeat (3) @(posedge hclk);
        conclude();
    end

endmodule : internal_memory_size_config_tb
